// >>> design/partial_store_pkg.sv
// constants and types shared by the partial word store unit
package partial_store_pkg;
   localparam int unsigned WordWidth = 32;
   localparam int unsigned AddrWidth = 32;
   localparam int unsigned CacheAttrWidth = 3;
   localparam int unsigned FullImmWidth = 16;
   localparam int unsigned ShortImmWidth = 9;
   localparam int unsigned ByteLanes = 4;
   // architecture revision that drops the whole left/right family
   localparam logic [3:0] RevNoPartial = 4'h6;
   localparam logic [3:0] RevReset = 4'h2;

   typedef enum logic [3:0]
   {
      OP_LEFT = 4'h1,
      OP_RIGHT = 4'h2,
      OP_LEFT_USER = 4'h4,
      OP_RIGHT_USER = 4'h8
   } store_op_e;

   // segment access modes that the user-mapped variants may reach
   typedef enum logic [2:0]
   {
      SEG_UNMAPPED_USER = 3'h1,
      SEG_MAPPED_USER_KERNEL = 3'h2,
      SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL = 3'h4
   } seg_mode_e;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h1,
      ST_XLATE = 3'h2,
      ST_ISSUE = 3'h4
   } store_state_e;

   // exception codes raised on the pipeline side
   localparam logic [3:0] ExcNone = 4'h0;
   localparam logic [3:0] ExcReservedInstr = 4'h1;
   localparam logic [3:0] ExcCopUnusable = 4'h2;
   localparam logic [3:0] ExcTlbRefill = 4'h3;
   localparam logic [3:0] ExcTlbInvalid = 4'h4;
   localparam logic [3:0] ExcTlbModified = 4'h5;
   localparam logic [3:0] ExcBusError = 4'h6;
   localparam logic [3:0] ExcAddrError = 4'h7;
   localparam logic [3:0] ExcWatch = 4'h8;
endpackage

// >>> design/partial_store_lanes.sv
// byte selection, data alignment and write enables for partial stores
`timescale 1ns/100ps
`default_nettype none
module partial_store_lanes
   import partial_store_pkg::*;
(
   input wire logic isLeft,
   input wire logic [1:0] addrLow,
   input wire logic coreMsbFirst,
   input wire logic [WordWidth-1:0] srcWord,
   output logic [1:0] byteIndex,
   output logic [WordWidth-1:0] storeData,
   output logic [ByteLanes-1:0] laneEnable
);
   always_comb
   begin
      byteIndex = addrLow ^ {2{coreMsbFirst}};
      storeData = '0;
      laneEnable = '0;
      if (isLeft)
      begin
         // high bytes of the source go to the low lanes of the word
         storeData = srcWord >> (5'h18 - {byteIndex, 3'h0});
         for (int i = 0; i < ByteLanes; i++)
         begin
            laneEnable[i] = (2'(i) <= byteIndex);
         end
      end
      else
      begin
         storeData = srcWord << {byteIndex, 3'h0};
         for (int i = 0; i < ByteLanes; i++)
         begin
            laneEnable[i] = (2'(i) >= byteIndex);
         end
      end
   end
endmodule
`default_nettype wire

// >>> design/partial_store_unit.sv
// partial word store unit: address, translation request and store issue
// Contract
// - plain stores add sign-extended 16-bit immediate
// - user-map variants add sign-extended 9-bit immediate
// - left store writes high source bytes
// - right store writes low source bytes
// - byte choice from address low bits, endianness
// - xor physical low bits with reverse flag
// - little-endian memory forces low bits zero
// - byte index and shifted data, index-sized
// - left plus right covers whole word
// - plain store reports translation, bus, watch faults
// - variants translate through user mapping in mapped-user/super/unmapped-kernel mode only
// - variants exist only when enhanced addressing set
// - variants need coprocessor zero, enhanced segment
// - variants add reserved and unusable faults
// - revision six omits the family entirely
`timescale 1ns/100ps
`default_nettype none
module partial_store_unit
   import partial_store_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   // pipeline side
   input wire logic reqValid,
   input wire partial_store_pkg::store_op_e reqOp,
   input wire logic [partial_store_pkg::WordWidth-1:0] baseWord,
   input wire logic [partial_store_pkg::WordWidth-1:0] srcWord,
   input wire logic [partial_store_pkg::FullImmWidth-1:0] immediate,
   input wire logic [3:0] archRevision,
   input wire logic enhancedVirtualAddressing,
   input wire logic cop0Usable,
   input wire partial_store_pkg::seg_mode_e segMode,
   input wire logic coreMsbFirstFlag,
   input wire logic memoryMsbFirstFlag,
   input wire logic swapByteOrderFlag,
   output logic reqReady,
   output logic excValid,
   output logic [3:0] excCode,
   output logic doneValid,
   // translation side
   output logic xlateValid,
   output logic [partial_store_pkg::AddrWidth-1:0] virtualAddr,
   output logic xlateUserMap,
   input wire logic xlateDone,
   input wire logic [partial_store_pkg::AddrWidth-1:0] xlatePhysAddr,
   input wire logic [partial_store_pkg::CacheAttrWidth-1:0] cacheCoherencyAttr,
   input wire logic [3:0] xlateFault,
   // memory side
   output logic memValid,
   output logic [partial_store_pkg::AddrWidth-1:0] memAddr,
   output logic [partial_store_pkg::CacheAttrWidth-1:0] memAttr,
   output logic [1:0] memSize,
   output logic [partial_store_pkg::WordWidth-1:0] memData,
   output logic [partial_store_pkg::ByteLanes-1:0] memByteEnable,
   input wire logic memReady,
   input wire logic memBusError
);
   import partial_store_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   store_state_e state_reg, state_next;
   logic reqReady_reg, reqReady_next;
   logic excValid_reg, excValid_next;
   logic [3:0] excCode_reg, excCode_next;
   logic doneValid_reg, doneValid_next;
   logic xlateValid_reg, xlateValid_next;
   logic [AddrWidth-1:0] virtual_addr_reg, virtual_addr_next;
   logic xlateUserMap_reg, xlateUserMap_next;
   logic isLeft_reg, isLeft_next;
   logic coreMsb_reg, coreMsb_next;
   logic [WordWidth-1:0] src_reg, src_next;
   logic memValid_reg, memValid_next;
   logic [AddrWidth-1:0] memAddr_reg, memAddr_next;
   logic [CacheAttrWidth-1:0] memAttr_reg, memAttr_next;
   logic [1:0] memSize_reg, memSize_next;
   logic [WordWidth-1:0] memData_reg, memData_next;
   logic [ByteLanes-1:0] memBe_reg, memBe_next;

   logic [1:0] laneIndex;
   logic [WordWidth-1:0] laneData;
   logic [ByteLanes-1:0] laneEnable;
   logic isUserVariant;
   logic [AddrWidth-1:0] effectiveAddr;
   logic [AddrWidth-1:0] physAdjusted;

   // ----------------------------------------
   // lane selection
   // ----------------------------------------
   partial_store_lanes lanes
   (
      .isLeft(isLeft_reg),
      .addrLow(virtual_addr_reg[1:0]),
      .coreMsbFirst(coreMsb_reg),
      .srcWord(src_reg),
      .byteIndex(laneIndex),
      .storeData(laneData),
      .laneEnable(laneEnable)
   );

   // ----------------------------------------
   // address forming
   // ----------------------------------------
   always_comb
   begin
      isUserVariant = (reqOp == OP_LEFT_USER) || (reqOp == OP_RIGHT_USER);
      if (isUserVariant)
      begin
         // only the low nine immediate bits are carried by these encodings
         effectiveAddr = baseWord + {{(AddrWidth-ShortImmWidth){immediate[ShortImmWidth-1]}},
                                     immediate[ShortImmWidth-1:0]};
      end
      else
      begin
         effectiveAddr = baseWord + {{(AddrWidth-FullImmWidth){immediate[FullImmWidth-1]}},
                                     immediate};
      end
      physAdjusted = xlatePhysAddr;
      physAdjusted[1:0] = xlatePhysAddr[1:0] ^ {2{swapByteOrderFlag}};
      if (!memoryMsbFirstFlag)
      begin
         physAdjusted[1:0] = 2'h0;
      end
   end

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_comb
   begin
      state_next = state_reg;
      reqReady_next = 1'b0;
      excValid_next = 1'b0;
      excCode_next = excCode_reg;
      doneValid_next = 1'b0;
      xlateValid_next = xlateValid_reg;
      virtual_addr_next = virtual_addr_reg;
      xlateUserMap_next = xlateUserMap_reg;
      isLeft_next = isLeft_reg;
      coreMsb_next = coreMsb_reg;
      src_next = src_reg;
      memValid_next = memValid_reg;
      memAddr_next = memAddr_reg;
      memAttr_next = memAttr_reg;
      memSize_next = memSize_reg;
      memData_next = memData_reg;
      memBe_next = memBe_reg;
      unique case (state_reg)
         ST_IDLE:
         begin
            reqReady_next = 1'b1;
            if (reqValid && reqReady_reg)
            begin
               reqReady_next = 1'b0;
               if (archRevision >= RevNoPartial)
               begin
                  excValid_next = 1'b1;
                  excCode_next = ExcReservedInstr;
               end
               else if (isUserVariant && !enhancedVirtualAddressing)
               begin
                  excValid_next = 1'b1;
                  excCode_next = ExcReservedInstr;
               end
               else if (isUserVariant && !cop0Usable)
               begin
                  excValid_next = 1'b1;
                  excCode_next = ExcCopUnusable;
               end
               else if (isUserVariant && !(segMode inside {SEG_UNMAPPED_USER,
                        SEG_MAPPED_USER_KERNEL, SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL}))
               begin
                  excValid_next = 1'b1;
                  excCode_next = ExcAddrError;
               end
               else
               begin
                  virtual_addr_next = effectiveAddr;
                  isLeft_next = (reqOp == OP_LEFT) || (reqOp == OP_LEFT_USER);
                  // user mapping only matters in the mapped-user/super/unmapped-kernel mode
                  xlateUserMap_next = isUserVariant
                     && (segMode == SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL);
                  coreMsb_next = coreMsbFirstFlag;
                  src_next = srcWord;
                  xlateValid_next = 1'b1;
                  state_next = ST_XLATE;
               end
            end
         end
         ST_XLATE:
         begin
            if (xlateDone)
            begin
               xlateValid_next = 1'b0;
               if (xlateFault != ExcNone)
               begin
                  excValid_next = 1'b1;
                  excCode_next = xlateFault;
                  state_next = ST_IDLE;
               end
               else
               begin
                  memAddr_next = physAdjusted;
                  memAttr_next = cacheCoherencyAttr;
                  memSize_next = laneIndex;
                  memData_next = laneData;
                  memBe_next = laneEnable;
                  memValid_next = 1'b1;
                  state_next = ST_ISSUE;
               end
            end
         end
         ST_ISSUE:
         begin
            if (memReady)
            begin
               memValid_next = 1'b0;
               state_next = ST_IDLE;
               if (memBusError)
               begin
                  excValid_next = 1'b1;
                  excCode_next = ExcBusError;
               end
               else
               begin
                  doneValid_next = 1'b1;
               end
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         state_reg <= ST_IDLE;
         reqReady_reg <= 1'b0;
         excValid_reg <= 1'b0;
         excCode_reg <= ExcNone;
         doneValid_reg <= 1'b0;
         xlateValid_reg <= 1'b0;
         virtual_addr_reg <= '0;
         xlateUserMap_reg <= 1'b0;
         isLeft_reg <= 1'b0;
         coreMsb_reg <= 1'b0;
         src_reg <= '0;
         memValid_reg <= 1'b0;
         memAddr_reg <= '0;
         memAttr_reg <= '0;
         memSize_reg <= 2'h0;
         memData_reg <= '0;
         memBe_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         reqReady_reg <= reqReady_next;
         excValid_reg <= excValid_next;
         excCode_reg <= excCode_next;
         doneValid_reg <= doneValid_next;
         xlateValid_reg <= xlateValid_next;
         virtual_addr_reg <= virtual_addr_next;
         xlateUserMap_reg <= xlateUserMap_next;
         isLeft_reg <= isLeft_next;
         coreMsb_reg <= coreMsb_next;
         src_reg <= src_next;
         memValid_reg <= memValid_next;
         memAddr_reg <= memAddr_next;
         memAttr_reg <= memAttr_next;
         memSize_reg <= memSize_next;
         memData_reg <= memData_next;
         memBe_reg <= memBe_next;
      end
   end

   assign reqReady = reqReady_reg;
   assign excValid = excValid_reg;
   assign excCode = excCode_reg;
   assign doneValid = doneValid_reg;
   assign xlateValid = xlateValid_reg;
   assign virtualAddr = virtual_addr_reg;
   assign xlateUserMap = xlateUserMap_reg;
   assign memValid = memValid_reg;
   assign memAddr = memAddr_reg;
   assign memAttr = memAttr_reg;
   assign memSize = memSize_reg;
   assign memData = memData_reg;
   assign memByteEnable = memBe_reg;
endmodule
`default_nettype wire

// >>> verif/store_far_side_model.sv
// translation and memory responder facing the partial store unit
`timescale 1ns/100ps
`default_nettype none
module store_far_side_model
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic slow,
   input wire logic [3:0] faultCode,
   input wire logic busErr,
   input wire logic xlateValid,
   input wire logic [31:0] virtualAddr,
   input wire logic memValid,
   output logic xlateDone,
   output logic [31:0] xlatePhysAddr,
   output logic [2:0] cacheCoherencyAttr,
   output logic [3:0] xlateFault,
   output logic memReady,
   output logic memBusError
);
   // ----
   // responder
   // ----
   logic [1:0] waitCnt;
   wire logic pend = (xlateValid && !xlateDone) || (memValid && !memReady);
   wire logic go = pend && (!slow || waitCnt == 2'h2);
   // released lines invert so a stale value is never mistaken for an answer
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         {xlateDone, memReady, memBusError, waitCnt} <= '0;
         {xlatePhysAddr, cacheCoherencyAttr, xlateFault} <= '0;
      end
      else
      begin
         waitCnt <= pend && !go ? waitCnt + 2'h1 : 2'h0;
         xlateDone <= go && xlateValid;
         memReady <= go && memValid;
         memBusError <= go && memValid ? busErr : ~memBusError;
         xlatePhysAddr <= go && xlateValid ? virtualAddr ^ 32'h1000_0000 : ~xlatePhysAddr;
         cacheCoherencyAttr <= go && xlateValid ? 3'h3 : ~cacheCoherencyAttr;
         xlateFault <= go && xlateValid ? faultCode : ~xlateFault;
      end
   end
endmodule
`default_nettype wire

// >>> verif/partial_store_assertions.sv
// concurrent checks on the partial store unit ports
`timescale 1ns/100ps
`default_nettype none
module partial_store_assertions
   import partial_store_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic [3:0] archRevision,
   input wire logic memoryMsbFirstFlag,
   input wire logic excValid,
   input wire logic [3:0] excCode,
   input wire logic doneValid,
   input wire logic xlateValid,
   input wire logic [31:0] virtualAddr,
   input wire logic xlateDone,
   input wire logic [3:0] xlateFault,
   input wire logic memValid,
   input wire logic [31:0] memAddr,
   input wire logic [31:0] memData,
   input wire logic [3:0] memByteEnable,
   input wire logic memReady,
   input wire logic memBusError
);
   // ----
   // properties
   // ----
   default clocking mainClk @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   AST_TAKE: assert property (reqValid && reqReady |=> !reqReady && (xlateValid || excValid))
      else $error("take not answered");
   AST_REV6: assert property (reqValid && reqReady && archRevision >= 4'h6 |=> excValid
      && excCode == ExcReservedInstr && !xlateValid) else $error("revision six not refused");
   AST_XLATE_HOLD: assert property (xlateValid && !xlateDone |=> xlateValid && $stable(virtualAddr))
      else $error("translation request dropped");
   AST_FAULT: assert property (xlateValid && xlateDone && xlateFault != ExcNone |=> excValid
      && excCode == $past(xlateFault) && !memValid) else $error("fault not passed on");
   AST_MEM_HOLD: assert property (memValid && !memReady |=> memValid && $stable(memData)
      && $stable(memAddr) && $stable(memByteEnable)) else $error("store request changed");
   AST_LITTLE_MEM: assert property (memValid && !memoryMsbFirstFlag |-> memAddr[1:0] == 2'h0)
      else $error("low address bits not cleared");
   AST_DONE: assert property (memValid && memReady && !memBusError |=> doneValid && !excValid)
      else $error("store not completed");
   AST_BUS_ERR: assert property (memValid && memReady && memBusError |=> excValid
      && excCode == ExcBusError && !doneValid) else $error("bus error lost");
   AST_LANES: assert property (memValid |-> memByteEnable[0] || memByteEnable[3])
      else $error("lanes not anchored at a word end");
   cover property (memValid && memReady && !memBusError);
   cover property (excValid && excCode == ExcBusError);
   cover property (xlateValid && xlateDone && xlateFault != ExcNone);
endmodule
bind partial_store_unit partial_store_assertions partial_store_assertions_inst (.*);
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the partial word store unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import partial_store_pkg::*;
   logic sys_clk = 0, rst_b = 0, reqValid = 0, reqReady, excValid, doneValid, xlateValid;
   logic xlateUserMap, xlateDone, memValid, memReady, memBusError, slow = 0, busErr = 0;
   logic enhancedVirtualAddressing = 1, cop0Usable = 1, coreMsbFirstFlag = 0, um, gotMem;
   logic memoryMsbFirstFlag = 1, swapByteOrderFlag = 0;
   store_op_e reqOp = OP_LEFT;
   seg_mode_e segMode = SEG_UNMAPPED_USER;
   logic [31:0] baseWord = 0, srcWord = 32'h1122_3344, virtualAddr, xlatePhysAddr;
   logic [31:0] memAddr, memData, va, mAddr, mData;
   logic [15:0] immediate = 0;
   logic [3:0] archRevision = RevReset, excCode, xlateFault, faultCode = 0, memByteEnable, mBe, code;
   logic [2:0] cacheCoherencyAttr, memAttr, mAttr;
   logic [1:0] memSize, mSize;
   int errorCnt = 0, checkCount = 0, cycles = 0;
   partial_store_unit partial_store_unit_inst (.*);
   store_far_side_model store_far_side_model_inst (.*);
   // ----
   // clock, timeout, shared tasks
   // ----
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         errorCnt++;
         results();
      end
   end
   task automatic results();
      if (errorCnt == 0 && checkCount > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // inputs move at the falling edge; pulses are sampled there too
   task automatic run(input store_op_e op, input logic [31:0] base, input logic [15:0] imm);
      int n;
      n = 0;
      gotMem = 0;
      // unknown captures so a missing transfer can never reuse an old match
      {va, um, mAddr, mData, mBe, mSize, mAttr} = 'x;
      reqOp = op;
      {baseWord, immediate, reqValid} = {base, imm, 1'b1};
      while (reqReady !== 1'b1)
         @(negedge sys_clk);
      @(negedge sys_clk);
      reqValid = 0;
      while (doneValid !== 1'b1 && excValid !== 1'b1 && n++ < 40)
      begin
         if (xlateValid === 1'b1)
            {va, um} = {virtualAddr, xlateUserMap};
         if (memValid === 1'b1)
         begin
            {mAddr, mData, mBe, mSize, gotMem} = {memAddr, memData, memByteEnable, memSize, 1'b1};
            mAttr = memAttr;
         end
         @(negedge sys_clk);
      end
      chk("answered", 32'h1, {31'h0, doneValid || excValid});
      code = excCode;
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic checkStore(input logic left, input logic [31:0] ea);
      logic [1:0] ix;
      logic [1:0] lo;
      ix = ea[1:0] ^ {2{coreMsbFirstFlag}};
      lo = memoryMsbFirstFlag ? ea[1:0] ^ {2{swapByteOrderFlag}} : 2'h0;
      chk("virtualAddr", ea, va);
      chk("memAddr", {ea[31:28] ^ 4'h1, ea[27:2], lo}, mAddr);
      chk("memData", left ? srcWord >> (24 - 8 * ix) : srcWord << (8 * ix), mData);
      chk("memByteEnable", {28'h0, left ? 4'hF >> (3 - ix) : 4'hF << ix}, {28'h0, mBe});
      chk("memSize", {30'h0, ix}, {30'h0, mSize});
      chk("memAttr", 32'h3, {29'h0, mAttr});
   endtask
   task automatic refuse(input store_op_e op, input logic [3:0] exp);
      run(op, 32'h0, 16'h0);
      chk("excCode", {28'h0, exp}, {28'h0, code});
      chk("memIssued", 0, {31'h0, gotMem});
   endtask
   // ----
   // scenarios
   // ----
   task automatic testLanes();
      for (int k = 0; k < 16; k++)
      begin
         {memoryMsbFirstFlag, coreMsbFirstFlag, slow} = {~k[3], k[2], k[0]};
         swapByteOrderFlag = k[1] ^ k[0];
         run(k[3] ? OP_RIGHT : OP_LEFT, 32'h2000_0108 + k, 16'hFFF8);
         checkStore(!k[3], 32'h2000_0100 + k);
      end
   endtask
   task automatic testPair();
      int total;
      coreMsbFirstFlag = 1;
      run(OP_LEFT, 32'h100, 16'h2);
      total = $countones(mBe);
      run(OP_RIGHT, 32'h100, 16'h5);
      chk("pairBytes", 4, total + $countones(mBe));
   endtask
   task automatic testUser();
      for (int k = 0; k < 6; k++)
      begin
         segMode = k < 2 ? SEG_UNMAPPED_USER : SEG_MAPPED_USER_KERNEL;
         if (k > 3)
            segMode = SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL;
         run(k[0] ? OP_RIGHT_USER : OP_LEFT_USER, 32'h4000_0013, 16'h01F0);
         checkStore(!k[0], 32'h4000_0003);
         chk("xlateUserMap", {31'h0, k > 3}, {31'h0, um});
      end
   endtask
   task automatic testRefuse();
      archRevision = RevNoPartial;
      refuse(OP_LEFT, ExcReservedInstr);
      archRevision = RevReset;
      enhancedVirtualAddressing = 0;
      refuse(OP_RIGHT_USER, ExcReservedInstr);
      enhancedVirtualAddressing = 1;
      cop0Usable = 0;
      refuse(OP_LEFT_USER, ExcCopUnusable);
      cop0Usable = 1;
      segMode = seg_mode_e'(3'h3);
      refuse(OP_RIGHT_USER, ExcAddrError);
      segMode = SEG_UNMAPPED_USER;
   endtask
   task automatic testFaults();
      for (int k = 0; k < 4; k++)
      begin
         faultCode = k == 3 ? ExcWatch : 4'(k + 3);
         refuse(OP_RIGHT, faultCode);
      end
      {faultCode, busErr} = {ExcNone, 1'b1};
      run(OP_LEFT, 32'h0, 16'h0);
      chk("excCode", {28'h0, ExcBusError}, {28'h0, code});
      busErr = 0;
   endtask
   initial
   begin
      repeat (16) @(negedge sys_clk);
      rst_b = 1;
      testLanes();
      testPair();
      testUser();
      testRefuse();
      testFaults();
      results();
   end
endmodule
`default_nettype wire
